// >>> verilog/adcsq_pkg.sv
// Package of constants and types for the converter sequencing block.
// How it works
// (RULE1) Each conversion takes ten converter clock ticks.
// (RULE2) Converter clock divides system clock by software.
// (RULE3) Result is unsigned linear eight-bit code.
// (RULE4) Mode control channel field routes one input.
// (RULE5) Software waits 100 us after enable first.
// (RULE6) Scan field and continuous bit choose mode.
// (RULE7) Software disables converter before changing mode.
// (RULE8) Single mode: result zero, clear start, flag.
// (RULE9) Completion flag raises interrupt when enabled.
// (RULE10) Continuous single channel fills four, flags, keeps.
// (RULE11) Continuous single channel wraps three to zero.
// (RULE12) Software reads results before the buffer wraps.
// (RULE13) Start cleared: finish conversion, stop, flag.
// (RULE14) Scan single: four channels, clear start, flag.
// (RULE15) Scan continuous repeats sets, flags each set.
// (RULE16) Scan stop finishes the whole set first.
// (RULE17) Settle delay before conversion, hold during it.
// (RULE18) Completion flag set on store, cleared by read.
// (RULE19) Busy reads one only while converting; the code reads one whenever the sequencer is not idle, settle delay included.
// (RULE20) Store into unread register sets overrun, continues.
// (RULE21) Overrun cleared only by writing one; the code also clears it whenever the converter is disabled.
// (RULE22) Pointer loads three on start, increments.
// (RULE23) Status register resets to 30 hex.
// (RULE24) Disable aborts and clears flags and start.
// (RULE25) Reading any result register clears interrupt.
// (RULE26) Divide codes give 1 to 32.
// (RULE27) Delay codes give 1 to 64 ticks.
// (RULE28) Register is full from store until read.
// (RULE29) Scan advances channel by one each conversion.
package adcsq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   localparam int ADDR_W = 3;
   typedef logic [ADDR_W-1:0] adcsq_addr_t;

   localparam adcsq_addr_t ADDR_STATUS = 3'h0;
   localparam adcsq_addr_t ADDR_ENABLE = 3'h1;
   localparam adcsq_addr_t ADDR_MODE   = 3'h2;
   localparam adcsq_addr_t ADDR_TIMING = 3'h3;
   localparam adcsq_addr_t ADDR_DATA0  = 3'h4;

   localparam int EN_BIT    = 0;
   localparam int IRQEN_BIT = 2;
   localparam int START_BIT = 7;
   localparam int SCAN_LSB  = 5;
   localparam int CONTINUOUS_SELECT_BIT  = 4;
   localparam int CHAN_LSB  = 0;
   localparam int CLOCK_DIVIDE_SELECT_LSB  = 0;
   localparam int DELAY_LSB = 3;
   localparam int EOC_BIT   = 0;
   localparam int BUSY_BIT  = 1;
   localparam int OVF_BIT   = 2;
   localparam int PTR_LSB   = 4;

   localparam logic [1:0] SCAN_SINGLE = 2'h0;
   localparam logic [1:0] PTR_START   = 2'h3;
   localparam logic [1:0] LAST_SLOT   = 2'h3;
   localparam logic [7:0] STATUS_RESET = 8'h30;
   localparam logic [2:0] CLOCK_DIVIDE_SELECT_MAX    = 3'h5;
   localparam logic [2:0] DELAY_MAX   = 3'h6;

   // Timing: a conversion is the resolved bits plus a sample tick and a store tick.
   localparam int SAR_EXTRA_TICKS   = 2;
   localparam int SYS_CLK_NS        = 100;
   localparam int ADC_MIN_PERIOD_NS = 1000;
   localparam int ADC_MIN_DIV       = (ADC_MIN_PERIOD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_SETTLE = 3'h2,
      ST_CONV   = 3'h4
   } adcsq_state_t;

endpackage

// >>> verilog/adcsq_clkdiv.sv
// Converter clock divider producing a one-cycle tick enable.
`timescale 1ns/1ps
module adcsq_clkdiv #(
   parameter int SEL_W = 3
) (
   input  wire logic             mclk,
   input  wire logic             arst_n,
   input  wire logic             run,
   input  wire logic [SEL_W-1:0] divSel,
   output logic                  tick
);
   import adcsq_pkg::*;

   localparam int CNT_W = 5;

   initial begin
      if (SEL_W != 3) $error("adcsq_clkdiv supports a three bit divide select only");
   end

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic [2:0]       selSat;

   // Reserved codes saturate to the slowest divide rather than run too fast.
   always_comb begin
      selSat = (divSel > CLOCK_DIVIDE_SELECT_MAX) ? CLOCK_DIVIDE_SELECT_MAX : divSel;
      limit  = CNT_W'((32'h0000_0001 << selSat) - 32'h0000_0001); // RULE26
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (!run || cnt_q >= limit) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= run && (cnt_q >= limit); // RULE2
      end
   end

   a_div_two_gap: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
      (tick && run && divSel == 3'h1 && $stable(divSel)) |=> !tick)
      else $error("divide by two produced back to back ticks");

endmodule // adcsq_clkdiv

// >>> verilog/adcsq_top.sv
// Sequencer, successive approximation control and registers of the converter.
`timescale 1ns/1ps
module adcsq_top #(
   parameter int RES_BITS = 8
) (
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire adcsq_pkg::adcsq_addr_t regAddr,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   input  wire logic [7:0]            regWrData,
   output logic      [7:0]            regRdData,
   output logic                       irq,
   output logic      [2:0]            chanSel,
   output logic                       sampleHold,
   output logic      [RES_BITS-1:0]   dacCode,
   input  wire logic                  cmpAbove
);
   import adcsq_pkg::*;

   localparam int CONV_TICKS = RES_BITS + SAR_EXTRA_TICKS;
   localparam int IDX_W      = (RES_BITS > 1) ? $clog2(RES_BITS) : 1;

   initial begin
      if (RES_BITS < 1 || RES_BITS > 8) $error("RES_BITS must lie between 1 and 8");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers.

   function automatic logic isDataAddr(input adcsq_addr_t a);
      isDataAddr = (a >= ADDR_DATA0);
   endfunction

   function automatic logic [1:0] dataSlot(input adcsq_addr_t a);
      dataSlot = 2'(a - ADDR_DATA0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers.

   logic                enable_q;
   logic                irqEnable_q;
   logic                start_q;
   logic [1:0]          scan_q;
   logic                continuous_select_q;
   logic [3:0]          chanBase_q;
   logic [2:0]          clock_divide_select_q;
   logic [2:0]          delay_q;
   logic                eoc_q;
   logic                ovf_q;
   logic [1:0]          ptr_q;
   logic [3:0]          full_q;
   logic [RES_BITS-1:0] data_q [4];

   adcsq_state_t        state_q;
   logic [1:0]          convIdx_q;
   logic [6:0]          settleCnt_q;
   logic [3:0]          convCnt_q;
   logic [IDX_W-1:0]    bitIdx_q;
   logic                tick;

   logic                wrEnable;
   logic                wrMode;
   logic                wrTiming;
   logic                wrStatus;
   logic                dataRead;
   logic                startRise;
   logic                storeNow;
   logic                lastOfSet;
   logic                stopNow;
   logic                eocNow;
   logic                hwClearStart;
   logic [1:0]          nextPtr;
   logic [6:0]          settleLen;
   logic [RES_BITS-1:0] sarNext;
   logic [2:0]          delaySat;

   always_comb begin
      wrEnable  = regWr && (regAddr == ADDR_ENABLE);
      wrMode    = regWr && (regAddr == ADDR_MODE);
      wrTiming  = regWr && (regAddr == ADDR_TIMING);
      wrStatus  = regWr && (regAddr == ADDR_STATUS);
      dataRead  = regRd && isDataAddr(regAddr);
      startRise = enable_q && wrMode && regWrData[START_BIT] && !start_q;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         enable_q    <= 1'b0;
         irqEnable_q <= 1'b0;
      end else if (wrEnable) begin
         enable_q    <= regWrData[EN_BIT];
         irqEnable_q <= regWrData[IRQEN_BIT];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clock_divide_select_q  <= '0;
         delay_q <= '0;
      end else if (wrTiming) begin
         clock_divide_select_q  <= regWrData[CLOCK_DIVIDE_SELECT_LSB +: 3];
         delay_q <= regWrData[DELAY_LSB +: 3];
      end
   end

   // Scan and continuous bits are frozen while start is set so a running sequence keeps its shape.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scan_q     <= SCAN_SINGLE;
         continuous_select_q     <= 1'b0;
         chanBase_q <= '0;
      end else if (wrMode) begin
         chanBase_q <= regWrData[CHAN_LSB +: 4];
         if (!start_q) begin
            scan_q <= regWrData[SCAN_LSB +: 2];
            continuous_select_q <= regWrData[CONTINUOUS_SELECT_BIT];
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         start_q <= 1'b0;
      end else if (!enable_q) begin
         start_q <= 1'b0; // RULE24
      end else if (wrMode) begin
         start_q <= regWrData[START_BIT];
      end else if (hwClearStart) begin
         start_q <= 1'b0; // RULE8 RULE14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Converter clock and sequencing.

   adcsq_clkdiv #(
      .SEL_W (3)
   ) u_clkdiv (
      .mclk   (mclk),
      .arst_n (arst_n),
      .run    (enable_q),
      .divSel (clock_divide_select_q),
      .tick   (tick)
   );

   always_comb begin
      delaySat  = (delay_q > DELAY_MAX) ? DELAY_MAX : delay_q;
      settleLen = 7'(32'h0000_0001 << delaySat); // RULE27
      storeNow  = enable_q && (state_q == ST_CONV) && tick
                  && (convCnt_q == 4'(CONV_TICKS - 1)); // RULE1
      lastOfSet = (convIdx_q == LAST_SLOT);
      nextPtr   = 2'(ptr_q + 2'h1);
      // RULE6: the four modes differ in when a pass stops and flags, and the scan modes also step chanSel.
      if (!continuous_select_q) begin
         stopNow = (scan_q == SCAN_SINGLE) ? 1'b1 : lastOfSet; // RULE8 RULE14
      end else if (scan_q == SCAN_SINGLE) begin
         stopNow = !start_q; // RULE13
      end else begin
         stopNow = lastOfSet && !start_q; // RULE16
      end
      eocNow       = storeNow && (stopNow || lastOfSet); // RULE10 RULE15
      hwClearStart = storeNow && stopNow && !continuous_select_q;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q     <= ST_IDLE;
         convIdx_q   <= '0;
         settleCnt_q <= '0;
         convCnt_q   <= '0;
      end else if (!enable_q) begin
         state_q <= ST_IDLE; // RULE24
      end else begin
         case (state_q)
            ST_IDLE: begin
               convIdx_q   <= '0;
               settleCnt_q <= '0;
               if (start_q) begin
                  state_q <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (tick) begin
                  if (settleCnt_q == 7'(settleLen - 7'h01)) begin
                     state_q   <= ST_CONV; // RULE17
                     convCnt_q <= '0;
                  end else begin
                     settleCnt_q <= settleCnt_q + 7'h01;
                  end
               end
            end
            ST_CONV: begin
               if (tick) begin
                  convCnt_q <= convCnt_q + 4'h1;
               end
               if (storeNow) begin
                  settleCnt_q <= '0;
                  convIdx_q   <= convIdx_q + 2'h1;
                  state_q     <= stopNow ? ST_IDLE : ST_SETTLE; // RULE11 RULE15
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Channel is driven while settling so the multiplexer output has the delay to settle.
   // The next scan channel is presented at the store itself, otherwise a one-tick settle
   // would close the hold on the previous input.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         chanSel <= '0;
      end else if (scan_q == SCAN_SINGLE) begin
         chanSel <= chanBase_q[2:0]; // RULE4
      end else if (storeNow) begin
         chanSel <= 3'(chanBase_q[2:0] + {1'b0, 2'(convIdx_q + 2'h1)}); // RULE29
      end else begin
         chanSel <= 3'(chanBase_q[2:0] + {1'b0, convIdx_q}); // RULE29
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sampleHold <= 1'b0;
      end else begin
         sampleHold <= enable_q && (state_q == ST_SETTLE) && tick
                       && (settleCnt_q == 7'(settleLen - 7'h01))
                       || (enable_q && state_q == ST_CONV && !storeNow); // RULE17
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Successive approximation: tick 0 holds, ticks 1..RES_BITS resolve, last stores.

   always_comb begin
      sarNext = dacCode;
      if (!cmpAbove) begin
         sarNext[bitIdx_q] = 1'b0;
      end
      if (bitIdx_q != '0) begin
         sarNext[bitIdx_q - 1'b1] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dacCode  <= '0;
         bitIdx_q <= '0;
      end else if (state_q == ST_SETTLE) begin
         dacCode  <= RES_BITS'(1) << (RES_BITS - 1);
         bitIdx_q <= IDX_W'(RES_BITS - 1);
      end else if (state_q == ST_CONV && tick && convCnt_q != 4'h0
                   && convCnt_q <= 4'(RES_BITS)) begin
         dacCode <= sarNext; // RULE3
         if (bitIdx_q != '0) begin
            bitIdx_q <= bitIdx_q - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result buffer, pointer and flags.

   always_ff @(posedge mclk) begin
      if (storeNow) begin
         data_q[nextPtr] <= dacCode; // RULE3 RULE11
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_q <= PTR_START; // RULE23
      end else if (startRise) begin
         ptr_q <= PTR_START; // RULE22
      end else if (storeNow) begin
         ptr_q <= nextPtr; // RULE22
      end
   end

   // A read and a store to the same slot in one cycle leave it full: the store wins.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         full_q <= '0;
      end else if (!enable_q) begin
         full_q <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (storeNow && nextPtr == 2'(i)) begin
               full_q[i] <= 1'b1; // RULE28
            end else if (dataRead && dataSlot(regAddr) == 2'(i)) begin
               full_q[i] <= 1'b0; // RULE28
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_q <= 1'b0;
      end else if (!enable_q) begin
         ovf_q <= 1'b0; // RULE24
      end else if (storeNow && full_q[nextPtr]) begin
         ovf_q <= 1'b1; // RULE20
      end else if (wrStatus && regWrData[OVF_BIT]) begin
         ovf_q <= 1'b0; // RULE21
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         eoc_q <= 1'b0;
      end else if (!enable_q) begin
         eoc_q <= 1'b0; // RULE24
      end else if (eocNow) begin
         eoc_q <= 1'b1; // RULE18
      end else if (dataRead) begin
         eoc_q <= 1'b0; // RULE18
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else if (!enable_q) begin
         irq <= 1'b0;
      end else if (eocNow && irqEnable_q) begin
         irq <= 1'b1; // RULE9
      end else if (dataRead) begin
         irq <= 1'b0; // RULE25
      end
   end

   // Read data is registered, so it appears the cycle after the read strobe.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= '0;
      end else if (regRd) begin
         if (regAddr == ADDR_STATUS) begin
            regRdData <= {2'h0, ptr_q, 1'b0, ovf_q, (state_q != ST_IDLE), eoc_q}; // RULE19
         end else if (regAddr == ADDR_ENABLE) begin
            regRdData <= {5'h00, irqEnable_q, 1'b0, enable_q};
         end else if (regAddr == ADDR_MODE) begin
            regRdData <= {start_q, scan_q, continuous_select_q, chanBase_q};
         end else if (regAddr == ADDR_TIMING) begin
            regRdData <= {2'h0, delay_q, clock_divide_select_q};
         end else begin
            regRdData <= 8'(data_q[dataSlot(regAddr)]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_start_ptr_load: assert property (@(posedge mclk) disable iff (!arst_n) // RULE22
      startRise |=> (ptr_q == PTR_START))
      else $error("pointer did not load three on start");

   a_ptr_advance: assert property (@(posedge mclk) disable iff (!arst_n) // RULE22
      (storeNow && !startRise) |=> (ptr_q == 2'($past(ptr_q) + 2'h1)))
      else $error("pointer did not advance on a store");

   a_disable_clears: assert property (@(posedge mclk) disable iff (!arst_n) // RULE24
      !enable_q |=> (!eoc_q && !ovf_q && !start_q && !irq && state_q == ST_IDLE))
      else $error("disable left a flag or the sequencer active");

   a_eoc_raises_irq: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
      (eocNow && irqEnable_q) |=> (irq && eoc_q))
      else $error("completion did not raise the interrupt");

   a_read_clears: assert property (@(posedge mclk) disable iff (!arst_n) // RULE25
      (dataRead && !eocNow) |=> (!irq && !eoc_q))
      else $error("data read did not clear completion and interrupt");

   a_ovf_on_full: assert property (@(posedge mclk) disable iff (!arst_n) // RULE20
      (storeNow && full_q[nextPtr]) |=> ovf_q ##1
      (ovf_q || $past(!enable_q) || $past(wrStatus && regWrData[OVF_BIT])))
      else $error("store into full register did not set overrun");

   a_ovf_sticky: assert property (@(posedge mclk) disable iff (!arst_n) // RULE21
      (ovf_q && enable_q && !(wrStatus && regWrData[OVF_BIT])) |=> ovf_q)
      else $error("overrun cleared without a one written");

   a_single_stop: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
      (storeNow && !continuous_select_q && scan_q == SCAN_SINGLE && !wrMode)
      |=> (!start_q && eoc_q && ptr_q == 2'h0 && state_q == ST_IDLE))
      else $error("single conversion did not stop in slot zero");

   a_hold_in_conv: assert property (@(posedge mclk) disable iff (!arst_n) // RULE17
      (state_q == ST_CONV && $past(state_q) == ST_CONV && !storeNow) |-> sampleHold)
      else $error("sample not held during conversion");

   a_conv_ticks: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
      storeNow |-> (bitIdx_q == '0 && sampleHold && convCnt_q == 4'(CONV_TICKS - 1)))
      else $error("store outside the last conversion tick");

   c_single_done: cover property (@(posedge mclk) disable iff (!arst_n)
      storeNow && !continuous_select_q && scan_q == SCAN_SINGLE);
   c_scan_set: cover property (@(posedge mclk) disable iff (!arst_n)
      eocNow && scan_q != SCAN_SINGLE && continuous_select_q);
   c_overrun: cover property (@(posedge mclk) disable iff (!arst_n)
      storeNow && full_q[nextPtr]);

endmodule // adcsq_top

// >>> tb/adcsq_analog_model.sv
// Behavioural model of the analog multiplexer, sample-and-hold and comparator.
`timescale 1ns/1ps
module adcsq_analog_model (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic [2:0] chanSel,
   input  wire logic       sampleHold,
   input  wire logic [7:0] dacCode,
   output logic            cmpAbove
);
   ////////////////////////////////////////////////////////////////////////////////
   // Fixed level per input; the bench keeps its own copy for its expectations.
   localparam logic [7:0] LEVEL [8] = '{8'h00, 8'hFF, 8'h5A, 8'hA5,
                                        8'h80, 8'h7F, 8'h01, 8'hC3};
   logic [7:0] heldQ;
   logic       junkQ;

   // The level follows the mux while open and freezes once the hold closes.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         heldQ <= 8'h00;
      end else if (!sampleHold) begin
         heldQ <= LEVEL[chanSel];
      end
   end

   // Outside hold the comparator means nothing, so it wanders to expose early use.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         junkQ <= 1'h0;
      end else begin
         junkQ <= ~junkQ;
      end
   end

   assign cmpAbove = sampleHold ? (heldQ >= dacCode) : junkQ;
endmodule // adcsq_analog_model

// >>> tb/testbench.sv
// Self-checking bench for the converter sequencing block.
`timescale 1ns/1ps
module testbench;
   import adcsq_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct {logic [7:0] tim; int ch; int dv; int tk;} adcsq_tbrow_t;
   localparam logic [7:0] LVL [8] = '{8'h00, 8'hFF, 8'h5A, 8'hA5,
                                      8'h80, 8'h7F, 8'h01, 8'hC3};
   // Timing code, channel, divide factor, ticks of settle plus conversion.
   adcsq_tbrow_t rows [8] = '{'{8'h00, 0, 1, 11}, '{8'h01, 1, 2, 11},
      '{8'h02, 2, 4, 11}, '{8'h03, 3, 8, 11}, '{8'h04, 4, 16, 11},
      '{8'h05, 5, 32, 11}, '{8'h30, 7, 1, 74}, '{8'h0A, 6, 4, 12}};

   logic         mclk;
   logic         arst_n;
   adcsq_addr_t  regAddr;
   logic         regWr;
   logic         regRd;
   logic [7:0]   regWrData;
   logic [7:0]   regRdData;
   logic         irq;
   logic [2:0]   chanSel;
   logic         sampleHold;
   logic [7:0]   dacCode;
   logic         cmpAbove;
   int           failCount = 0;
   int           totalChecks = 0;

   adcsq_top #(.RES_BITS(8)) u_adcsq_top (.mclk(mclk), .arst_n(arst_n),
      .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
      .regRdData(regRdData), .irq(irq), .chanSel(chanSel),
      .sampleHold(sampleHold), .dacCode(dacCode), .cmpAbove(cmpAbove));

   adcsq_analog_model u_adcsq_analog_model (.mclk(mclk), .arst_n(arst_n),
      .chanSel(chanSel), .sampleHold(sampleHold), .dacCode(dacCode),
      .cmpAbove(cmpAbove));

   initial mclk = 1'h0;
   always #50 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkIn(input int n, input int lo, input int hi);
      totalChecks++;
      if (n < lo || n > hi) begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
      end
   endtask

   task automatic wr(input adcsq_addr_t a, input logic [7:0] d);
      @(posedge mclk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'h1;
      @(posedge mclk);
      regWr     <= 1'h0;
   endtask

   // Read data is registered, so it is taken just after the edge that answers.
   task automatic rdChk(input adcsq_addr_t a, input logic [7:0] m, input logic [7:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRd   <= 1'h1;
      @(posedge mclk);
      regRd   <= 1'h0;
      #1;
      chk(regRdData & m, e);
   endtask

   task automatic waitIrq(output int n);
      n = 0;
      while (irq !== 1'h1) begin
         if (n == 3000) begin
            failCount++;
            summarize;
         end
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   // Busy only rises a cycle after start is taken, so polling begins later.
   task automatic waitIdle;
      int k;
      k = 0;
      repeat (4) @(posedge mclk);
      #1;
      while (u_adcsq_top.regRdData[1] !== 1'h0 || k == 0) begin
         if (k == 300) begin
            failCount++;
            summarize;
         end
         @(posedge mclk);
         regAddr <= ADDR_STATUS;
         regRd   <= 1'h1;
         @(posedge mclk);
         regRd   <= 1'h0;
         #1;
         k++;
      end
   endtask

   task automatic setup(input logic [7:0] tim);
      wr(ADDR_ENABLE, 8'h00);
      wr(ADDR_TIMING, tim);
      wr(ADDR_ENABLE, 8'h05);
      repeat (1000) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      arst_n    <= 1'h0;
      regAddr   <= ADDR_STATUS;
      regWr     <= 1'h0;
      regRd     <= 1'h0;
      regWrData <= 8'h00;
      repeat (16) @(posedge mclk);
      arst_n <= 1'h1;
      rdChk(ADDR_STATUS, 8'hFF, 8'h30);
      foreach (rows[i]) begin
         setup(rows[i].tim);
         wr(ADDR_MODE, 8'h80 | 8'(rows[i].ch));
         waitIrq(n);
         chkIn(n, (rows[i].tk - 1) * rows[i].dv, rows[i].tk * rows[i].dv + 6);
         rdChk(ADDR_STATUS, 8'hFF, 8'h01);
         rdChk(ADDR_MODE, 8'h80, 8'h00);
         rdChk(ADDR_DATA0, 8'hFF, LVL[rows[i].ch]);
         chk({7'h00, irq}, 8'h00);
         rdChk(ADDR_STATUS, 8'h01, 8'h00);
      end
      setup(8'h00);
      wr(ADDR_MODE, 8'hA6);
      waitIrq(n);
      rdChk(ADDR_STATUS, 8'hFF, 8'h31);
      rdChk(ADDR_MODE, 8'hFF, 8'h26);
      for (int i = 0; i < 4; i++) begin
         rdChk(ADDR_DATA0 + 3'(i), 8'hFF, LVL[(6 + i) % 8]);
      end
      setup(8'h00);
      wr(ADDR_MODE, 8'h82);
      waitIdle;
      wr(ADDR_MODE, 8'h82);
      waitIdle;
      rdChk(ADDR_STATUS, 8'hFF, 8'h05);
      wr(ADDR_STATUS, 8'hFB);
      rdChk(ADDR_STATUS, 8'hFF, 8'h05);
      wr(ADDR_STATUS, 8'h04);
      rdChk(ADDR_STATUS, 8'hFF, 8'h01);
      setup(8'h00);
      wr(ADDR_MODE, 8'h93);
      waitIrq(n);
      rdChk(ADDR_STATUS, 8'h31, 8'h31);
      rdChk(ADDR_MODE, 8'h80, 8'h80);
      for (int i = 0; i < 4; i++) begin
         rdChk(ADDR_DATA0 + 3'(i), 8'hFF, LVL[3]);
      end
      wr(ADDR_MODE, 8'h13);
      waitIdle;
      rdChk(ADDR_STATUS, 8'h3F, 8'h11);
      setup(8'h00);
      wr(ADDR_MODE, 8'hB4);
      waitIrq(n);
      rdChk(ADDR_MODE, 8'h80, 8'h80);
      wr(ADDR_MODE, 8'h34);
      waitIdle;
      rdChk(ADDR_STATUS, 8'h37, 8'h35);
      for (int i = 0; i < 4; i++) begin
         rdChk(ADDR_DATA0 + 3'(i), 8'hFF, LVL[(4 + i) % 8]);
      end
      setup(8'h05);
      wr(ADDR_MODE, 8'h80);
      repeat (40) @(posedge mclk);
      rdChk(ADDR_STATUS, 8'h07, 8'h02);
      wr(ADDR_ENABLE, 8'h00);
      rdChk(ADDR_STATUS, 8'h07, 8'h00);
      rdChk(ADDR_MODE, 8'h80, 8'h00);
      summarize;
   end
endmodule // testbench
